// ==== bench/sld_decoder_assertions.sv ====
`timescale 1ns/1ns
module sld_decoder_checker
    import sld_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Decoder outputs
    input wire logic       byte_ready,
    input wire logic       dec_valid,
    input wire logic [2:0] op_class,
    input wire logic [2:0] shift_op_select_field,
    input wire logic       mem_operand,
    input wire logic       flags_only,
    input wire logic [3:0] exec_clocks,
    input wire logic       exec_busy,
    input wire logic       exec_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic       sh;
    logic [3:0] busy_q;
    assign sh = dec_valid && op_class == CLS_SHIFT;
    // Busy run length, judged at its last cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) busy_q <= 4'h0;
        else busy_q <= exec_busy ? busy_q + 4'h1 : 4'h0;
    end
    a_busy_length: assert property (exec_done |-> busy_q + 4'h1 == exec_clocks) else $error("run");
    a_exec_start: assert property (dec_valid |-> exec_busy && !byte_ready) else $error("start");
    a_done_frees: assert property (exec_done |=> !exec_busy && byte_ready) else $error("free");
    a_issue_valid: assert property ($fell(byte_ready) |=> dec_valid) else $error("issue");
    a_carry_clocks: assert property (sh && shift_op_select_field[2:1] == 2'b01 |->
        exec_clocks == (mem_operand ? 4'ha : 4'h9)) else $error("carry");
    a_plain_clocks: assert property (sh && shift_op_select_field[2:1] != 2'b01 |->
        exec_clocks == (mem_operand ? 4'h7 : 4'h3)) else $error("plain");
    a_double_clocks: assert property (dec_valid && op_class inside {CLS_DSHL, CLS_DSHR} |->
        exec_clocks == (mem_operand ? 4'h7 : 4'h3)) else $error("double");
    a_test_flags: assert property (dec_valid && op_class == CLS_TEST |->
        flags_only && exec_clocks == (mem_operand ? 4'h5 : 4'h2)) else $error("test");
    c_carry_mem: cover property (sh && mem_operand && shift_op_select_field == ROTATE_RIGHT_CARRY_OP);
    c_double: cover property (dec_valid && op_class == CLS_DSHR);
    c_test_mem: cover property (dec_valid && flags_only && mem_operand);
endmodule : sld_decoder_checker

bind sld_decoder sld_decoder_checker u_sld_decoder_checker (.clk(clk), .rst(rst), .byte_ready(byte_ready),
    .dec_valid(dec_valid), .op_class(op_class), .shift_op_select_field(shift_op_select_field),
    .mem_operand(mem_operand), .flags_only(flags_only), .exec_clocks(exec_clocks),
    .exec_busy(exec_busy), .exec_done(exec_done));

// ==== bench/sld_fetch_model.sv ====
`timescale 1ns/1ns
module sld_fetch_model (
    // Clock, reset, byte handshake
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       byte_ready,
    output logic            byte_valid = 1'b0,
    output logic [7:0]      byte_data = 8'h00
);
    logic [7:0] q[$];
    logic       slow = 1'b0;
    logic       took = 1'b0;
    always @(posedge clk) took <= byte_valid && byte_ready;
    // Offer held until taken; idle data toggles so no stale byte looks valid
    always @(negedge clk) begin
        if (took) void'(q.pop_front());
        if (took || !byte_valid) begin
            byte_valid = !rst && q.size() != 0 && !(slow && $urandom_range(1));
            byte_data = byte_valid ? q[0] : ~byte_data;
        end
    end
endmodule : sld_fetch_model

// ==== bench/test_shift_logic_op_decoder.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t %h", $time, a); end end
module test_shift_logic_op_decoder
    import sld_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, opsize_16 = 1'b0, byte_valid, byte_ready, dec_valid, dec_error;
    logic        width_bit, dir_bit, mem_operand, flags_only, exec_busy, exec_done, md;
    logic [7:0]  byte_data, o, ot[9] = '{8'h80, 8'h81, 8'h83, 8'hf6, 8'hf7, 8'h24, 8'h25, 8'ha8, 8'ha9};
    logic [2:0]  op_class, shift_op_select_field, c;
    logic [1:0]  count_src;
    logic [3:0]  exec_clocks;
    logic [31:0] imm_data, r;
    logic [48:0] eq[$], x;
    int          err_count = 0, comparisons = 0, cyc = 0, i, k, m, p, n;
    always #25 clk = ~clk;
    sld_decoder u_sld_decoder (.clk(clk), .rst(rst), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(byte_ready), .opsize_16(opsize_16), .dec_valid(dec_valid), .dec_error(dec_error),
        .op_class(op_class), .shift_op_select_field(shift_op_select_field), .count_src(count_src),
        .width_bit(width_bit), .dir_bit(dir_bit), .mem_operand(mem_operand), .flags_only(flags_only),
        .exec_clocks(exec_clocks), .imm_data(imm_data), .exec_busy(exec_busy), .exec_done(exec_done));
    sld_fetch_model u_sld_fetch_model (.clk(clk), .rst(rst), .byte_ready(byte_ready),
        .byte_valid(byte_valid), .byte_data(byte_data));
    function automatic logic [7:0] mr(int mm, logic [2:0] r);
        return {mm ? 2'b00 : 2'b11, r, 3'($urandom)};
    endfunction : mr
    task automatic ins(int nb, logic [47:0] v, logic [11:0] e, logic [36:0] a);
        for (int j = 0; j < nb; j++) u_sld_fetch_model.q.push_back(v[8*j+:8]);
        eq.push_back({a, e});
    endtask : ins
    task automatic drain();
        while (eq.size() != 0 || !byte_ready) @(negedge clk);
    endtask : drain
    task test_done();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    always @(negedge clk) if (!rst && (dec_valid || dec_error)) begin
        x = eq.size() != 0 ? eq.pop_front() : 49'h7ff;
        if (dec_error) `CHK(1'b1, x[11])
        else begin
            `CHK({1'b0, op_class, shift_op_select_field, exec_clocks, mem_operand}, x[11:0])
            `CHK({imm_data, count_src, flags_only, width_bit, dir_bit}, x[48:12])
        end
    end
    always @(posedge clk) if (++cyc == 20000) begin
        err_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'h1167));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 48; i++) begin
            k = i % 3; m = (i / 3) % 2; c = 3'(i / 6); r = $urandom;
            o = k == 0 ? 8'hc0 : (k == 1 ? 8'hd0 : 8'hd2);
            o[0] = r[8];
            ins(c == 6 || k != 0 ? 2 : 3, {24'h0, r[7:0], mr(m, c), o}, c == 6 ? 12'h800 :
                {1'b0, CLS_SHIFT, c, c[2:1] == 2'b01 ? (m ? 4'ha : 4'h9) : (m ? 4'h7 : 4'h3), m[0]},
                {k ? 32'h0 : r & 32'hff, k == 0 ? CNT_IMM : (k == 1 ? CNT_ONE : CNT_REG), 1'b0, o[0], o[1]});
        end
        for (i = 0; i < 8; i++) begin
            m = i % 2; p = i / 2; r = $urandom;
            ins(p % 2 ? 3 : 4, {16'h0, r[7:0], mr(m, 3'($urandom)), 8'ha4 | 8'(p[1] * 8 + p[0]), 8'h0f},
                {1'b0, p[1] ? CLS_DSHR : CLS_DSHL, 3'h0, m ? 4'h7 : 4'h3, m[0]},
                {p % 2 ? 32'h0 : r & 32'hff, p % 2 ? CNT_REG : CNT_IMM, 3'b010});
        end
        for (i = 0; i < 20; i++) begin
            m = i % 2; p = i / 2;
            o = p < 4 ? 8'h20 + 8'(p) : (p < 8 ? 8'h04 + 8'(p) : 8'h7c + 8'(p));
            c = p < 4 ? CLS_AND : (p < 8 ? CLS_OR : CLS_TEST);
            ins(2, {32'h0, mr(m, 3'($urandom)), o},
                {1'b0, c, 3'h0, !m ? 4'h2 : (c == CLS_TEST ? 4'h5 : (o[1] ? 4'h6 : 4'h7)), m[0]},
                {34'h0, c == CLS_TEST, o[0], o[1]});
        end
        for (p = 0; p < 2; p++) begin
            drain();
            opsize_16 = 1'(p);
            u_sld_fetch_model.slow = 1'(p);
            for (i = 0; i < 18; i++) begin
                m = i % 2; k = i / 2; o = ot[k]; md = k < 5; r = $urandom;
                c = k inside {3, 4, 7, 8} ? CLS_TEST : CLS_AND;
                n = !o[0] || k == 2 ? 1 : (p ? 2 : 4);
                ins(n + 1 + md, md ? {r, mr(m, c == CLS_AND ? 3'h4 : 3'h0), o} : {8'h0, r, o},
                    {1'b0, c, 3'h0, md && m ? (c == CLS_TEST ? 4'h5 : 4'h7) : 4'h2, md && m},
                    {r & ~(32'hffffffff << 8 * n), 2'h0, c == CLS_TEST, o[0], 1'b0});
            end
        end
        ins(1, 48'h90, 12'h800, 37'h0);
        ins(1, 48'h82, 12'h800, 37'h0);
        ins(2, {32'h0, mr(0, 3'h1), 8'h80}, 12'h800, 37'h0);
        ins(2, {32'h0, mr(1, 3'h1), 8'hf6}, 12'h800, 37'h0);
        ins(2, 48'h000f, 12'h800, 37'h0);
        ins(2, 48'h5524, {1'b0, CLS_AND, 3'h0, 4'h2, 1'b0}, {32'h55, 5'h0});
        drain();
        test_done();
    end
endmodule : test_shift_logic_op_decoder

// ==== rtl/sld_decoder.sv ====
`timescale 1ns/1ns

// Summary of operation
// - Shift op field codes seven ops, 110 unused
// - Through-carry rotates take 9 reg / 10 mem
// - Count-register shift form carries op in modrm
// - Double left shift immediate: 0F A4, 3/7
// - Double left shift by count register: 3/7
// - Double right shift immediate: 0F AC, 3/7
// - Double right shift by count register: 3/7
// - Register-register conjunction takes two clocks
// - Conjunction register into memory takes seven
// - Conjunction memory into register takes six
// - Immediate conjunction, reg field 100, 2/7
// - Accumulator immediate conjunction, no modrm, 2
// - Flag-only test register/memory, 2/5
// - Flag-only immediate test, reg 000, 2/5
// - Accumulator immediate test, no modrm, 2
// - Register-register disjunction takes two clocks
// - Plain shifts by one/count register: 3/7
module sld_decoder
    import sld_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Instruction byte stream from fetch path
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    output logic             byte_ready,
    input  wire logic        opsize_16,
    // Decoded operation to the datapath
    output logic             dec_valid,
    output logic             dec_error,
    output logic [2:0]       op_class,
    output logic [2:0]       shift_op_select_field,
    output logic [1:0]       count_src,
    output logic             width_bit,
    output logic             dir_bit,
    output logic             mem_operand,
    output logic             flags_only,
    output logic [3:0]       exec_clocks,
    output logic [31:0]      imm_data,
    // Execution timing
    output logic             exec_busy,
    output logic             exec_done
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // First count for a register operand, second for memory
    function automatic logic [3:0] pick_cycles(input logic [3:0] reg_cyc,
                                               input logic [3:0] mem_cyc,
                                               input logic       is_mem);
        pick_cycles = is_mem ? mem_cyc : reg_cyc;
    endfunction : pick_cycles

    function automatic logic [2:0] imm_bytes(input logic w, input logic os16);
        imm_bytes = !w ? 3'h1 : (os16 ? 3'h2 : 3'h4);
    endfunction : imm_bytes

    // Opcodes followed by modrm; the s=1, w=0 immediate form is refused
    function automatic logic opc_modrm(input logic [7:0] b);
        opc_modrm = b[7:1] == PFX_SHIFT_ONE || b[7:1] == PFX_SHIFT_CNT || b[7:1] == PFX_SHIFT_IMM
                 || b[7:1] == PFX_TEST_RM || b[7:1] == PFX_TEST_IMM || b[7:2] == PFX_AND_RM
                 || b[7:2] == PFX_OR_RM || (b[7:2] == PFX_GRP_IMM && b[1:0] != 2'h2);
    endfunction : opc_modrm

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sld_state_e  state_q;
    sld_class_e  cls_q;
    sld_check_e  chk_q;
    sld_count_e  cnt_q;
    logic [2:0]  sop_q;
    logic        width_q;
    logic        dir_q;
    logic        mem_q;
    logic        flags_q;
    logic [3:0]  cyc_q;
    logic [31:0] imm_q;
    logic [2:0]  imm_len_q;
    logic [1:0]  imm_idx_q;
    logic        valid_q;
    logic        error_q;

    logic        take;
    logic [1:0]  mr_mod;
    logic [2:0]  mr_reg;
    logic        mr_mem;
    logic        mr_bad;
    logic [3:0]  mr_cyc;
    logic        timer_load;
    logic        timer_busy;
    logic        timer_done;

    assign byte_ready = (state_q == ST_OPC) || (state_q == ST_ESC)
                     || (state_q == ST_MODRM) || (state_q == ST_IMM);
    assign take       = byte_valid && byte_ready;
    assign timer_load = (state_q == ST_ISSUE);

    assign mr_mod = byte_data[7:6];
    assign mr_reg = byte_data[5:3];
    assign mr_mem = (mr_mod != MOD_REGISTER);

    // ------------------------------------------------------------------
    // Modrm checks and clock counts
    // ------------------------------------------------------------------
    always_comb begin
        mr_bad = 1'b0;
        mr_cyc = CYC_RESET;
        case (cls_q)
            CLS_SHIFT: begin
                if (mr_reg == SHIFT_OP_UNUSED) begin
                    mr_bad = 1'b1;
                end else if (mr_reg == ROTATE_LEFT_CARRY_OP || mr_reg == ROTATE_RIGHT_CARRY_OP) begin
                    mr_cyc = pick_cycles(CYC_RC_REG, CYC_RC_MEM, mr_mem);
                end else begin
                    mr_cyc = pick_cycles(CYC_SHIFT_REG, CYC_SHIFT_MEM, mr_mem);
                end
            end
            CLS_DSHL, CLS_DSHR: begin
                mr_cyc = pick_cycles(CYC_DSH_REG, CYC_DSH_MEM, mr_mem);
            end
            CLS_AND, CLS_OR: begin
                if (chk_q == CHK_AND_IMM) begin
                    mr_bad = (mr_reg != REG_AND_IMM);
                    mr_cyc = pick_cycles(CYC_IMM_REG, CYC_IMM_MEM, mr_mem);
                end else if (!mr_mem) begin
                    mr_cyc = CYC_LOG_RR;
                end else if (dir_q) begin
                    mr_cyc = CYC_LOG_M2R;
                end else begin
                    mr_cyc = CYC_LOG_R2M;
                end
            end
            CLS_TEST: begin
                if (chk_q == CHK_TEST_IMM) begin
                    mr_bad = (mr_reg != REG_TEST_IMM);
                end
                mr_cyc = pick_cycles(CYC_TEST_REG, CYC_TEST_MEM, mr_mem);
            end
            default: begin
                mr_bad = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_OPC;
        end else begin
            case (state_q)
                ST_OPC: begin
                    if (take) begin
                        if (byte_data == OPC_ESCAPE) begin
                            state_q <= ST_ESC;
                        end else if (byte_data[7:1] == PFX_AND_ACC
                                  || byte_data[7:1] == PFX_TEST_ACC) begin
                            state_q <= ST_IMM;
                        end else if (opc_modrm(byte_data)) begin
                            state_q <= ST_MODRM;
                        end
                    end
                end
                ST_ESC: begin
                    if (take) begin
                        if (byte_data == OPC_DSHL_IMM || byte_data == OPC_DSHL_CNT
                         || byte_data == OPC_DSHR_IMM || byte_data == OPC_DSHR_CNT) begin
                            state_q <= ST_MODRM;
                        end else begin
                            state_q <= ST_OPC;
                        end
                    end
                end
                ST_MODRM: begin
                    if (take) begin
                        if (mr_bad) begin
                            state_q <= ST_OPC;
                        end else if (imm_len_q != LEN_RESET) begin
                            state_q <= ST_IMM;
                        end else begin
                            state_q <= ST_ISSUE;
                        end
                    end
                end
                ST_IMM: begin
                    if (take && ({1'b0, imm_idx_q} == imm_len_q - 3'h1)) begin
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    state_q <= ST_EXEC;
                end
                ST_EXEC: begin
                    if (timer_done) begin
                        state_q <= ST_OPC;
                    end
                end
                default: begin
                    state_q <= ST_OPC;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Opcode attributes
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cls_q     <= CLS_NONE;
            chk_q     <= CHK_NONE;
            cnt_q     <= CNT_NONE;
            width_q   <= 1'b0;
            dir_q     <= 1'b0;
            flags_q   <= 1'b0;
            imm_len_q <= LEN_RESET;
        end else if (take && state_q == ST_OPC) begin
            width_q   <= byte_data[0];
            dir_q     <= byte_data[1];
            chk_q     <= CHK_NONE;
            cnt_q     <= CNT_NONE;
            flags_q   <= 1'b0;
            imm_len_q <= LEN_RESET;
            cls_q     <= CLS_NONE;
            if (byte_data[7:1] == PFX_SHIFT_ONE) begin
                cls_q <= CLS_SHIFT;
                cnt_q <= CNT_ONE;
            end else if (byte_data[7:1] == PFX_SHIFT_CNT) begin
                cls_q <= CLS_SHIFT;
                cnt_q <= CNT_REG;
            end else if (byte_data[7:1] == PFX_SHIFT_IMM) begin
                cls_q     <= CLS_SHIFT;
                cnt_q     <= CNT_IMM;
                imm_len_q <= 3'h1;
            end else if (byte_data[7:2] == PFX_AND_RM) begin
                cls_q <= CLS_AND;
            end else if (byte_data[7:2] == PFX_OR_RM) begin
                cls_q <= CLS_OR;
            end else if (byte_data[7:2] == PFX_GRP_IMM) begin
                cls_q     <= CLS_AND;
                chk_q     <= CHK_AND_IMM;
                dir_q     <= 1'b0;
                // Sign-extended form carries a single byte
                imm_len_q <= byte_data[1] ? 3'h1 : imm_bytes(byte_data[0], opsize_16);
            end else if (byte_data[7:1] == PFX_AND_ACC) begin
                cls_q     <= CLS_AND;
                dir_q     <= 1'b0;
                imm_len_q <= imm_bytes(byte_data[0], opsize_16);
            end else if (byte_data[7:1] == PFX_TEST_RM) begin
                cls_q   <= CLS_TEST;
                flags_q <= 1'b1;
                dir_q   <= 1'b0;
            end else if (byte_data[7:1] == PFX_TEST_IMM) begin
                cls_q     <= CLS_TEST;
                chk_q     <= CHK_TEST_IMM;
                flags_q   <= 1'b1;
                dir_q     <= 1'b0;
                imm_len_q <= imm_bytes(byte_data[0], opsize_16);
            end else if (byte_data[7:1] == PFX_TEST_ACC) begin
                cls_q     <= CLS_TEST;
                flags_q   <= 1'b1;
                dir_q     <= 1'b0;
                imm_len_q <= imm_bytes(byte_data[0], opsize_16);
            end
        end else if (take && state_q == ST_ESC) begin
            // Double shifts always work on the full operand width
            width_q <= 1'b1;
            dir_q   <= 1'b0;
            if (byte_data == OPC_DSHL_IMM || byte_data == OPC_DSHR_IMM) begin
                cnt_q     <= CNT_IMM;
                imm_len_q <= 3'h1;
            end else begin
                cnt_q     <= CNT_REG;
            end
            cls_q <= (byte_data[3] == 1'b1) ? CLS_DSHR : CLS_DSHL;
        end
    end

    // ------------------------------------------------------------------
    // Modrm fields, cycle count and immediate capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sop_q <= ROTATE_LEFT_OP;
            mem_q <= 1'b0;
            cyc_q <= CYC_RESET;
        end else if (take && state_q == ST_OPC) begin
            // Short forms have no modrm and a fixed count
            sop_q <= ROTATE_LEFT_OP;
            mem_q <= 1'b0;
            cyc_q <= CYC_ACC;
        end else if (take && state_q == ST_MODRM) begin
            sop_q <= (cls_q == CLS_SHIFT) ? mr_reg : ROTATE_LEFT_OP;
            mem_q <= mr_mem;
            cyc_q <= mr_cyc;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            imm_q     <= IMM_RESET;
            imm_idx_q <= 2'h0;
        end else if (take && state_q == ST_OPC) begin
            imm_q     <= IMM_RESET;
            imm_idx_q <= 2'h0;
        end else if (take && state_q == ST_IMM) begin
            // Little-endian assembly of the immediate bytes
            imm_q[imm_idx_q*8 +: 8] <= byte_data;
            imm_idx_q               <= imm_idx_q + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Issue and error pulses
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_q <= 1'b0;
            error_q <= 1'b0;
        end else begin
            valid_q <= timer_load;
            error_q <= take && ((state_q == ST_MODRM && mr_bad)
                     || (state_q == ST_ESC && !(byte_data == OPC_DSHL_IMM || byte_data == OPC_DSHL_CNT
                                             || byte_data == OPC_DSHR_IMM || byte_data == OPC_DSHR_CNT))
                     || (state_q == ST_OPC && byte_data != OPC_ESCAPE && !opc_modrm(byte_data)
                         && byte_data[7:1] != PFX_AND_ACC && byte_data[7:1] != PFX_TEST_ACC));
        end
    end

    // ------------------------------------------------------------------
    // Execution timing: busy for the decoded clock count
    // ------------------------------------------------------------------
    sld_exec_timer u_timer (
        .clk   (clk),
        .rst   (rst),
        .load  (timer_load),
        .count (cyc_q),
        .busy  (timer_busy),
        .done  (timer_done)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign dec_valid             = valid_q;
    assign dec_error             = error_q;
    assign op_class              = cls_q;
    assign shift_op_select_field = sop_q;
    assign count_src             = cnt_q;
    assign width_bit             = width_q;
    assign dir_bit               = dir_q;
    assign mem_operand           = mem_q;
    assign flags_only            = flags_q;
    assign exec_clocks           = cyc_q;
    assign imm_data              = imm_q;
    assign exec_busy             = timer_busy;
    assign exec_done             = timer_done;

endmodule : sld_decoder

// ==== rtl/sld_exec_timer.sv ====
`timescale 1ns/1ns

module sld_exec_timer
    import sld_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Start
    input  wire logic       load,
    input  wire logic [3:0] count,
    // Status
    output logic            busy,
    output logic            done
);

    logic [3:0] count_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= CYC_RESET;
        end else if (load) begin
            count_q <= count;
        end else if (count_q != CYC_RESET) begin
            count_q <= count_q - 4'h1;
        end
    end

    // Busy for exactly the loaded number of clocks
    assign busy = (count_q != CYC_RESET);
    assign done = (count_q == 4'h1);

endmodule : sld_exec_timer

// ==== rtl/sld_pkg.sv ====
package sld_pkg;

    // ------------------------------------------------------------------
    // Decoder states (one-hot)
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_OPC   = 6'h01,
        ST_ESC   = 6'h02,
        ST_MODRM = 6'h04,
        ST_IMM   = 6'h08,
        ST_ISSUE = 6'h10,
        ST_EXEC  = 6'h20
    } sld_state_e;

    // ------------------------------------------------------------------
    // Operation classes, count sources, modrm reg checks
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_NONE  = 3'h0,
        CLS_SHIFT = 3'h1,
        CLS_DSHL  = 3'h2,
        CLS_DSHR  = 3'h3,
        CLS_AND   = 3'h4,
        CLS_TEST  = 3'h5,
        CLS_OR    = 3'h6
    } sld_class_e;

    typedef enum logic [1:0] {
        CNT_NONE = 2'h0,
        CNT_ONE  = 2'h1,
        CNT_REG  = 2'h2,
        CNT_IMM  = 2'h3
    } sld_count_e;

    typedef enum logic [1:0] {
        CHK_NONE     = 2'h0,
        CHK_AND_IMM  = 2'h1,
        CHK_TEST_IMM = 2'h2
    } sld_check_e;

    // ------------------------------------------------------------------
    // Shift operation select codes
    // ------------------------------------------------------------------
    localparam logic [2:0] ROTATE_LEFT_OP        = 3'h0;
    localparam logic [2:0] ROTATE_RIGHT_OP       = 3'h1;
    localparam logic [2:0] ROTATE_LEFT_CARRY_OP  = 3'h2;
    localparam logic [2:0] ROTATE_RIGHT_CARRY_OP = 3'h3;
    localparam logic [2:0] SHIFT_LEFT_OP         = 3'h4;
    localparam logic [2:0] LOGICAL_SHIFT_RIGHT_OP = 3'h5;
    localparam logic [2:0] SHIFT_OP_UNUSED       = 3'h6;
    localparam logic [2:0] ARITH_SHIFT_RIGHT_OP  = 3'h7;

    // ------------------------------------------------------------------
    // Opcode bytes and prefixes
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_ESCAPE    = 8'h0f;
    localparam logic [7:0] OPC_DSHL_IMM  = 8'ha4;
    localparam logic [7:0] OPC_DSHL_CNT  = 8'ha5;
    localparam logic [7:0] OPC_DSHR_IMM  = 8'hac;
    localparam logic [7:0] OPC_DSHR_CNT  = 8'had;
    localparam logic [6:0] PFX_SHIFT_ONE = 7'h68;
    localparam logic [6:0] PFX_SHIFT_CNT = 7'h69;
    localparam logic [6:0] PFX_SHIFT_IMM = 7'h60;
    localparam logic [6:0] PFX_AND_ACC   = 7'h12;
    localparam logic [6:0] PFX_TEST_RM   = 7'h42;
    localparam logic [6:0] PFX_TEST_IMM  = 7'h7b;
    localparam logic [6:0] PFX_TEST_ACC  = 7'h54;
    localparam logic [5:0] PFX_AND_RM    = 6'h08;
    localparam logic [5:0] PFX_OR_RM     = 6'h02;
    localparam logic [5:0] PFX_GRP_IMM   = 6'h20;
    localparam logic [2:0] REG_AND_IMM   = 3'h4;
    localparam logic [2:0] REG_TEST_IMM  = 3'h0;
    localparam logic [1:0] MOD_REGISTER  = 2'h3;

    // ------------------------------------------------------------------
    // Execution clock counts
    // ------------------------------------------------------------------
    localparam logic [3:0] CYC_SHIFT_REG = 4'h3;
    localparam logic [3:0] CYC_SHIFT_MEM = 4'h7;
    localparam logic [3:0] CYC_RC_REG    = 4'h9;
    localparam logic [3:0] CYC_RC_MEM    = 4'ha;
    localparam logic [3:0] CYC_DSH_REG   = 4'h3;
    localparam logic [3:0] CYC_DSH_MEM   = 4'h7;
    localparam logic [3:0] CYC_LOG_RR    = 4'h2;
    localparam logic [3:0] CYC_LOG_R2M   = 4'h7;
    localparam logic [3:0] CYC_LOG_M2R   = 4'h6;
    localparam logic [3:0] CYC_IMM_REG   = 4'h2;
    localparam logic [3:0] CYC_IMM_MEM   = 4'h7;
    localparam logic [3:0] CYC_ACC       = 4'h2;
    localparam logic [3:0] CYC_TEST_REG  = 4'h2;
    localparam logic [3:0] CYC_TEST_MEM  = 4'h5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] IMM_RESET    = 32'h0000_0000;
    localparam logic [3:0]  CYC_RESET    = 4'h0;
    localparam logic [2:0]  LEN_RESET    = 3'h0;

endpackage : sld_pkg
